//--- verilog/dcts_pkg.sv
package dcts_pkg;
	// register offsets on the plain register port
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h1;
	localparam logic [3:0] REG_CTRL = 4'h2;
	// function codes: read is 71 octal, write is 61 octal
	localparam logic [5:0] FN_READ = 6'h39;
	localparam logic [5:0] FN_WRITE = 6'h31;
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int CTL_TMO_NS = 1500;
	localparam int CTL_TMO_CYC = (CTL_TMO_NS / CLK_PERIOD_NS < 1) ? 1 : CTL_TMO_NS / CLK_PERIOD_NS;
	localparam int RUN_TMO_MS = 10;
	localparam int RUN_TMO_CYC_DEF = RUN_TMO_MS * 1000000 / CLK_PERIOD_NS;
	localparam int TMO_W = 20;
	// command register layout, low bits of the write data
	typedef struct packed {
		logic [2:0] drive_select;
		logic go;
		logic [5:0] func;
		logic [17:0] initial_list_pointer;
	} dcts_cmd_s;
	localparam int CMD_W = 28;
	localparam dcts_cmd_s CMD_RST = '0;
	// control register, bit 0
	localparam logic CTRL_RST = 1'b0;
	// sticky error flags
	typedef struct packed {
		logic power;
		logic illegal;
		logic access;
		logic exception;
		logic overrun;
		logic drive_parity;
		logic chan_parity;
		logic xfer_tmo;
		logic ctl_tmo;
		logic response;
	} dcts_err_s;
	localparam dcts_err_s ERR_RST = '0;
	// drive pins that cross into the mclk domain
	typedef struct packed {
		logic power_failure;
		logic selected_drive_access_error;
		logic drive_absent;
		logic control_ack;
		logic run_ack;
		logic block_end;
		logic drive_fault_line;
		logic fault_class_b;
		logic word_strobe;
		logic drive_parity_error;
		logic [17:0] data;
	} dcts_drv_in_s;
	// sequencer states, gray along the normal path
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SEIZE = 3'h1,
		ST_PTR = 3'h3,
		ST_CTL = 3'h2,
		ST_RUN = 3'h6,
		ST_XFER = 3'h7,
		ST_CHTERM = 3'h5
	} dcts_state_e;
endpackage : dcts_pkg

//--- verilog/dcts_sequencer.sv
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Operation
// - ignore command while busy, else load it
// - read uses function code 71 octal
// - power, function or access error inhibit start
// - set busy, request channel, wait grant
// - pointer out with device pulse, channel acknowledges
// - channel pulse starts control strobe cycle
// - control ack timeout flags response error
// - run asserted, drive answers run ack
// - run ack timeout flags response error
// - error stop disable: class B ends
// - channel parity handling as documented
// - empty assembly takes buffer, requests next
// - 36-bit word sent as two halves
// - strobe returned as write strobe
// - write strobe on empty, channel active: overrun
// - write strobe on empty, channel idle: zeros
// - block end continues or terminates on run
// - fault line sets flag, class terminates
// - fault before first pulse terminates directly
// - read word passed with device pulse
// - write uses function code 61 octal
// - read halves fill left then right
// - read strobe on full assembly: overrun
// - read parity error stops unless disabled
module dcts_sequencer
	import dcts_pkg::*;
#(
	parameter int RUN_TMO_CYC = RUN_TMO_CYC_DEF
)(
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// drive side, asynchronous pins
	input wire dcts_drv_in_s drv_in,
	output logic [5:0] drv_func,
	output logic [2:0] drive_select,
	output logic control_request_strobe,
	output logic run,
	output logic write_strobe,
	output logic [17:0] drv_data_out,
	output logic drv_data_oe,
	// data channel side, on mclk
	output logic channel_request,
	input wire logic channel_grant,
	output logic device_word_pulse,
	output logic [35:0] chan_data_out,
	input wire logic channel_word_pulse,
	input wire logic [35:0] chan_data_in,
	input wire logic chan_parity_error
);
	////////////////////////////////////////////////////////////////
	// state and storage
	dcts_state_e state_reg, state_next; // sequencer
	dcts_cmd_s command_reg; // loaded transfer command
	logic error_stop_disable; // control bit
	dcts_err_s err_reg; // sticky error flags
	logic done_reg; // transfer finished
	dcts_drv_in_s sync1_reg, sync2_reg, sync3_reg; // pin synchroniser and edge stage
	logic [TMO_W-1:0] tmo_cnt_reg; // response timer
	logic [35:0] chan_word_buffer; // channel side word
	logic cb_full_reg;
	logic [35:0] assembly_hold; // word being split or built
	logic ar_full_reg;
	logic half_reg; // 0: left half next, 1: right half next
	logic [17:0] half_word_buffer; // drive side half
	logic chan_seen_reg; // first channel pulse received
	logic dwp_reg; // device word pulse
	logic run_reg;
	logic [31:0] rdata_reg;
	// decoded events
	logic busy, is_write, cmd_take, illegal, inhibit;
	logic strobe_lead, strobe_trail, fault_rise, blk_end_rise;
	logic ctl_tmo, run_tmo, overrun, dpar_stop, cpar_stop;
	logic fault_b, fault_a_stop, ar_load_w, cb_load_r;
	logic [17:0] rd_half;

	////////////////////////////////////////////////////////////////
	// two flops on every drive pin; the third stage only feeds edge detection
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			sync3_reg <= '0;
		end
		else
		begin
			sync1_reg <= drv_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	////////////////////////////////////////////////////////////////
	// event decode
	assign busy = (state_reg != ST_IDLE);
	assign is_write = (command_reg.func == FN_WRITE);
	// only the two transfer codes are legal
	assign illegal = (reg_wdata[23:18] != FN_READ) && (reg_wdata[23:18] != FN_WRITE);
	assign cmd_take = reg_wr && (reg_addr == REG_CMD) && !busy && reg_wdata[24];
	assign inhibit = sync2_reg.power_failure || sync2_reg.selected_drive_access_error || illegal;
	// leading edge: drive presents/samples; trailing edge: next half moves
	assign strobe_lead = sync2_reg.word_strobe && !sync3_reg.word_strobe;
	assign strobe_trail = !sync2_reg.word_strobe && sync3_reg.word_strobe;
	assign fault_rise = sync2_reg.drive_fault_line && !sync3_reg.drive_fault_line;
	assign blk_end_rise = sync2_reg.block_end && !sync3_reg.block_end;
	// timer runs from the strobe that opened the wait
	assign ctl_tmo = (state_reg == ST_CTL) && !sync2_reg.control_ack
		&& ((tmo_cnt_reg >= TMO_W'(CTL_TMO_CYC)) || sync2_reg.drive_absent);
	assign run_tmo = (state_reg == ST_RUN) && !sync2_reg.run_ack
		&& (tmo_cnt_reg >= TMO_W'(RUN_TMO_CYC));
	// an empty assembly on a write strobe is fatal only while the channel still feeds us
	assign overrun = (state_reg == ST_XFER) && (is_write
		? (strobe_lead && !ar_full_reg && channel_grant)
		: (strobe_trail && ar_full_reg));
	assign dpar_stop = (state_reg == ST_XFER) && !is_write && strobe_trail
		&& sync2_reg.drive_parity_error && !error_stop_disable;
	// channel parity stops only with error stop disabled, kept as documented
	assign cpar_stop = busy && is_write && channel_word_pulse && chan_parity_error && error_stop_disable;
	assign fault_b = busy && fault_rise && sync2_reg.fault_class_b;
	assign fault_a_stop = busy && fault_rise && !sync2_reg.fault_class_b
		&& !error_stop_disable;
	// write: buffer to assembly; read: assembly to buffer
	assign ar_load_w = busy && is_write && cb_full_reg && !ar_full_reg;
	assign cb_load_r = busy && !is_write && ar_full_reg && !cb_full_reg;
	// read halves come straight off the synchronised data lines
	assign rd_half = sync2_reg.data;

	////////////////////////////////////////////////////////////////
	// next state
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE:
				if (cmd_take && !inhibit)
					state_next = ST_SEIZE;
			ST_SEIZE:
				if (channel_grant)
					state_next = ST_PTR;
			ST_PTR:
				if (channel_word_pulse)
					state_next = ST_CTL;
			ST_CTL:
				if (ctl_tmo)
					state_next = ST_IDLE;
				else if (sync2_reg.control_ack)
					state_next = ST_RUN;
			ST_RUN:
				if (run_tmo)
					state_next = ST_IDLE;
				else if (sync2_reg.run_ack)
					state_next = ST_XFER;
			ST_XFER:
				if (blk_end_rise && !run_reg)
					state_next = ST_IDLE;
			ST_CHTERM:
				state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
		// fatal conditions override the normal path
		if (busy && (overrun || dpar_stop || cpar_stop || fault_b))
			state_next = ST_IDLE;
		else if (fault_a_stop)
			state_next = chan_seen_reg ? ST_CHTERM : ST_IDLE;
	end

	// sequencer register
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			state_reg <= ST_IDLE;
		else
			state_reg <= state_next;
	end

	////////////////////////////////////////////////////////////////
	// command and control registers
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			command_reg <= CMD_RST;
			error_stop_disable <= CTRL_RST;
		end
		else
		begin
			if (cmd_take)
				command_reg <= dcts_cmd_s'(reg_wdata[CMD_W-1:0]);
			if (reg_wr && (reg_addr == REG_CTRL))
				error_stop_disable <= reg_wdata[0];
		end
	end

	////////////////////////////////////////////////////////////////
	// flags: a new command clears them, any event in the same cycle still sets
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			err_reg <= ERR_RST;
			done_reg <= 1'b0;
		end
		else
		begin
			if (cmd_take)
			begin
				err_reg <= ERR_RST;
				done_reg <= 1'b0;
				err_reg.power <= sync2_reg.power_failure;
				err_reg.access <= sync2_reg.selected_drive_access_error;
				err_reg.illegal <= illegal;
				done_reg <= inhibit;
			end
			else if (busy && state_next == ST_IDLE)
				done_reg <= 1'b1;
			if (ctl_tmo)
			begin
				err_reg.ctl_tmo <= 1'b1;
				err_reg.response <= 1'b1;
			end
			if (run_tmo)
			begin
				err_reg.xfer_tmo <= 1'b1;
				err_reg.response <= 1'b1;
			end
			if (busy && fault_rise)
				err_reg.exception <= 1'b1;
			if (fault_b && error_stop_disable)
				err_reg.ctl_tmo <= 1'b1;
			if (overrun)
				err_reg.overrun <= 1'b1;
			if (busy && !is_write && strobe_trail && sync2_reg.drive_parity_error)
				err_reg.drive_parity <= 1'b1;
			if (cpar_stop)
				err_reg.chan_parity <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// response timer, restarted as each strobe goes out
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			tmo_cnt_reg <= '0;
		else if (state_next != state_reg)
			tmo_cnt_reg <= '0;
		else if (tmo_cnt_reg != '1)
			tmo_cnt_reg <= tmo_cnt_reg + 1'b1;
	end

	////////////////////////////////////////////////////////////////
	// run: held while data still flows; negated once the channel has gone
	// and nothing is left to hand over, so the next block end finishes
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			run_reg <= 1'b0;
		else if (state_next == ST_IDLE || state_next == ST_CHTERM)
			run_reg <= 1'b0;
		else if (state_reg == ST_CTL && sync2_reg.control_ack)
			run_reg <= 1'b1;
		else if (state_reg == ST_XFER && !channel_grant && !cb_full_reg && (!is_write || !ar_full_reg))
			run_reg <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// data path
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			chan_word_buffer <= '0;
			cb_full_reg <= 1'b0;
			assembly_hold <= '0;
			ar_full_reg <= 1'b0;
			half_reg <= 1'b0;
			half_word_buffer <= '0;
			chan_seen_reg <= 1'b0;
			dwp_reg <= 1'b0;
		end
		else if (!busy)
		begin
			// clean slate for the next transfer
			cb_full_reg <= 1'b0;
			ar_full_reg <= 1'b0;
			half_reg <= 1'b0;
			chan_seen_reg <= 1'b0;
			dwp_reg <= 1'b0;
			half_word_buffer <= '0;
		end
		else
		begin
			dwp_reg <= (state_reg == ST_SEIZE && channel_grant) || ar_load_w || cb_load_r;
			if (state_reg == ST_SEIZE && channel_grant)
				chan_word_buffer <= {18'h00000, command_reg.initial_list_pointer};
			if (channel_word_pulse && state_reg != ST_SEIZE)
				chan_seen_reg <= 1'b1;
			if (is_write)
			begin
				// write: channel word into buffer, then into assembly
				if (channel_word_pulse && state_reg != ST_SEIZE)
				begin
					chan_word_buffer <= chan_data_in;
					cb_full_reg <= 1'b1;
				end
				else if (ar_load_w)
					cb_full_reg <= 1'b0;
				if (ar_load_w)
				begin
					assembly_hold <= chan_word_buffer;
					ar_full_reg <= 1'b1;
				end
				else if (state_reg == ST_XFER && strobe_trail && ar_full_reg)
				begin
					half_reg <= !half_reg;
					if (half_reg)
						ar_full_reg <= 1'b0;
				end
				// empty assembly drives zeros: zero fill of the sector tail
				half_word_buffer <= !ar_full_reg ? 18'h00000
					: (half_reg ? assembly_hold[17:0] : assembly_hold[35:18]);
			end
			else
			begin
				// read: halves from the drive build the word, left first
				if (state_reg == ST_XFER && strobe_trail && !ar_full_reg)
				begin
					half_word_buffer <= rd_half;
					if (half_reg)
					begin
						assembly_hold[17:0] <= rd_half;
						ar_full_reg <= 1'b1;
					end
					else
						assembly_hold[35:18] <= rd_half;
					half_reg <= !half_reg;
				end
				else if (cb_load_r)
					ar_full_reg <= 1'b0;
				if (cb_load_r)
				begin
					chan_word_buffer <= assembly_hold;
					cb_full_reg <= 1'b1;
				end
				else if (channel_word_pulse && state_reg != ST_PTR)
					cb_full_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// register read, data one cycle after the strobe
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			rdata_reg <= '0;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				REG_CMD: rdata_reg <= {4'h0, command_reg};
				REG_STAT: rdata_reg <= {17'h00000, state_reg, err_reg, done_reg, busy};
				REG_CTRL: rdata_reg <= {31'h00000000, error_stop_disable};
				default: rdata_reg <= '0; // unmapped reads zero
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs
	assign reg_rdata = rdata_reg;
	assign drv_func = command_reg.func;
	assign drive_select = command_reg.drive_select;
	assign control_request_strobe = (state_reg == ST_CTL);
	assign run = run_reg;
	assign write_strobe = (state_reg == ST_XFER) && is_write && sync2_reg.word_strobe;
	assign drv_data_out = half_word_buffer;
	assign drv_data_oe = (state_reg == ST_XFER) && is_write;
	// request drops on every termination, channel terminate included
	assign channel_request = busy && (state_reg != ST_CHTERM);
	assign device_word_pulse = dwp_reg;
	assign chan_data_out = chan_word_buffer;

	////////////////////////////////////////////////////////////////
	// checks
	localparam int A_CTL_MAX = 80;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);

	a_busy_ignore: assert property (busy && reg_wr && reg_addr == REG_CMD |=> $stable(command_reg))
		else $error("command loaded while busy");
	a_inhibit_stop: assert property (cmd_take && inhibit |=> done_reg && !busy && !channel_request)
		else $error("inhibited start not terminated");
	a_grant_pointer: assert property (state_reg == ST_SEIZE && channel_grant && !fault_b
		|=> device_word_pulse && chan_data_out[17:0] == command_reg.initial_list_pointer)
		else $error("pointer not sent on grant");
	a_ctl_bound: assert property ($rose(control_request_strobe) |-> ##[1:A_CTL_MAX] !control_request_strobe)
		else $error("control strobe outlived its timeout");
	a_ctl_tmo_flag: assert property (ctl_tmo |=> err_reg.response && err_reg.ctl_tmo && done_reg && !busy)
		else $error("control timeout not flagged");
	a_run_bound: assert property (state_reg == ST_RUN |-> tmo_cnt_reg <= TMO_W'(RUN_TMO_CYC))
		else $error("run wait exceeded its timeout");
	a_write_overrun: assert property (overrun |=> err_reg.overrun && !channel_request)
		else $error("overrun not stopping transfer");
	a_zero_fill: assert property (busy && is_write && !ar_full_reg ##1 busy |-> drv_data_out == 18'h00000)
		else $error("empty assembly not driving zeros");
	a_read_halves: assert property (state_reg == ST_XFER && !is_write && strobe_trail && !ar_full_reg && half_reg
		&& !dpar_stop && !fault_b && !fault_a_stop |=> ar_full_reg && assembly_hold[17:0] == $past(rd_half))
		else $error("second half not completing word");
	a_fault_b_end: assert property (fault_b |=> !busy && done_reg && err_reg.exception)
		else $error("class B fault not terminating");
	a_wstrobe_echo: assert property (state_reg == ST_XFER && is_write |-> write_strobe == sync2_reg.word_strobe)
		else $error("write strobe not echoed");

	c_write_done: cover property (busy && is_write ##1 !busy && done_reg && err_reg == ERR_RST);
	c_read_done: cover property (busy && !is_write ##1 !busy && done_reg && err_reg == ERR_RST);
	c_chan_term: cover property (state_reg == ST_CHTERM);
	c_ctl_timeout: cover property (ctl_tmo);
endmodule : dcts_sequencer

//--- verif/dcts_drive_model.sv
`timescale 1ns/1ps
// behavioural drive on the far side of the sequencer
module dcts_drive_model
	import dcts_pkg::*;
(
	// from the sequencer
	input wire logic control_request_strobe,
	input wire logic run,
	input wire logic write_strobe,
	input wire logic [17:0] drv_data_out,
	// to the sequencer
	output dcts_drv_in_s drv
);
	int ack_on = 1; // answer the control strobe at all
	int runack_on = 1; // answer run at all
	int dly = 100; // answer latency in ns, raised for a slow drive
	int nhalf = 8; // strobes in one block
	logic [17:0] rdq[$]; // halves to send on read
	logic [17:0] got[$]; // halves sampled on write
	////////////////////////////////////////////////////////////////
	// every pin idle at time zero
	initial drv = '0;
	// control cycle: ack after the latency, dropped when the strobe falls
	always @(posedge control_request_strobe)
	begin
		if (ack_on != 0)
		begin
			#(dly) drv.control_ack = 1'b1;
			wait (!control_request_strobe);
			drv.control_ack = 1'b0;
		end
	end
	// data cycle: answer run, then one block of strobes at 160 ns
	always @(posedge run)
	begin
		if (runack_on != 0)
		begin
			#(dly) drv.run_ack = 1'b1;
			repeat (nhalf)
			begin
				// a half is set up before the leading edge and held past the trailing one
				if (rdq.size() != 0)
					drv.data = rdq.pop_front();
				#40 drv.word_strobe = 1'b1;
				#80 drv.word_strobe = 1'b0;
				#40;
			end
			// lines released: show the inverse so a stale value cannot pass
			drv.data = ~drv.data;
			#100 drv.block_end = 1'b1;
			#200 drv.block_end = 1'b0;
		end
	end
	// run_ack follows run down
	always @(negedge run) drv.run_ack = 1'b0;
	// write data are taken on the strobe leading edge
	always @(posedge write_strobe) got.push_back(drv_data_out);
endmodule : dcts_drive_model

//--- verif/test_drive_channel_transfer_sequencer.sv
`timescale 1ns/1ps
// compares two values and counts the outcome
`define CHK(a, b) \
	begin \
		n_compared++; \
		if ((a) !== (b)) \
		begin \
			bad_count++; \
			$display("[ERR] %0t got %h exp %h", $time, (a), (b)); \
		end \
	end
module test_drive_channel_transfer_sequencer
	import dcts_pkg::*;
;
	// clock, reset and register port
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	// drive side
	dcts_drv_in_s drv_in;
	logic [5:0] drv_func;
	logic [2:0] drive_select;
	logic control_request_strobe, run, write_strobe, drv_data_oe;
	logic [17:0] drv_data_out;
	// channel side, played by the bench
	logic channel_request, device_word_pulse;
	logic channel_grant = 1'b0;
	logic channel_word_pulse = 1'b0;
	logic chan_parity_error = 1'b0;
	logic [35:0] chan_data_in = 36'h0;
	logic [35:0] chan_data_out;
	// reference model state
	int bad_count = 0;
	int n_compared = 0;
	integer seed = 32'h67efe9d4;
	logic [35:0] wq[$]; // replies the channel still holds
	logic [35:0] expw[$]; // read words the channel should see
	logic [17:0] exph[$]; // halves the drive should see
	logic [17:0] ptr; // pointer of the live command
	int keep = 0; // stay granted with nothing left, to force an overrun
	int perr = 0; // channel words carry a parity error
	int rdm = 0; // read transfer in progress
	int dwp_n = 0; // device pulses seen for this command
	////////////////////////////////////////////////////////////////
	dcts_sequencer #(.RUN_TMO_CYC(200)) uut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .drv_in(drv_in),
		.drv_func(drv_func), .drive_select(drive_select), .control_request_strobe(control_request_strobe),
		.run(run), .write_strobe(write_strobe), .drv_data_out(drv_data_out), .drv_data_oe(drv_data_oe),
		.channel_request(channel_request), .channel_grant(channel_grant),
		.device_word_pulse(device_word_pulse), .chan_data_out(chan_data_out),
		.channel_word_pulse(channel_word_pulse), .chan_data_in(chan_data_in),
		.chan_parity_error(chan_parity_error));
	dcts_drive_model drive (.control_request_strobe(control_request_strobe), .run(run),
		.write_strobe(write_strobe), .drv_data_out(drv_data_out), .drv(drv_in));
	////////////////////////////////////////////////////////////////
	// 50 MHz system clock
	initial
	begin
		forever #10 mclk = ~mclk;
	end
	// channel: checks the pointer and the read words on device pulses, answers a pulse one cycle later while replies remain
	always @(posedge mclk)
	begin
		logic [35:0] e;
		channel_word_pulse <= 1'b0;
		chan_parity_error <= 1'b0;
		if (device_word_pulse === 1'b1)
		begin
			e = (expw.size() != 0) ? expw[0] : 36'h0;
			if (dwp_n == 0)
				`CHK(chan_data_out[17:0], ptr)
			else if (expw.size() != 0)
				`CHK(chan_data_out, e)
			if (dwp_n != 0 && expw.size() != 0)
				void'(expw.pop_front());
			dwp_n++;
			if (wq.size() != 0)
			begin
				channel_word_pulse <= 1'b1;
				chan_data_in <= wq.pop_front();
				chan_parity_error <= perr[0];
				// on read the channel finishes with its last acknowledge
				if (wq.size() == 0 && rdm != 0)
					channel_grant <= 1'b0;
			end
			else if (keep == 0)
				channel_grant <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////
	// random 36-bit value from the fixed seed
	function automatic logic [35:0] rnd36();
		logic [63:0] t;
		t = {$random(seed), $random(seed)};
		return t[35:0];
	endfunction : rnd36
	// one register write cycle
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	// one register read cycle, data taken in the following cycle
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	// fills the model queues, then issues the command with drive 5
	task automatic go(input logic [5:0] fn, input int nw);
		int i;
		logic [35:0] w;
		wq.delete();
		exph.delete();
		expw.delete();
		drive.rdq.delete();
		drive.got.delete();
		dwp_n = 0;
		w = rnd36();
		ptr = w[17:0];
		if (rdm != 0)
			wq.push_back(w);
		for (i = 0; i < nw; i++)
		begin
			w = rnd36();
			wq.push_back(w);
			if (rdm != 0)
			begin
				drive.rdq.push_back(w[35:18]);
				drive.rdq.push_back(w[17:0]);
				expw.push_back(w);
			end
			else
			begin
				exph.push_back(w[35:18]);
				exph.push_back(w[17:0]);
			end
		end
		// once the channel is gone the block is padded with zeros
		while (rdm == 0 && exph.size() < drive.nhalf)
			exph.push_back(18'h0);
		wr(REG_CMD, {4'h0, 3'h5, 1'b1, fn, ptr});
	endtask : go
	// polls until busy falls, compares the status, lets the drive settle
	task automatic fin(input logic [14:0] e);
		logic [31:0] s;
		int i;
		s = 32'h1;
		for (i = 0; i < 2000 && s[0] !== 1'b0; i++)
			rd(REG_STAT, s);
		`CHK(s[14:0], e)
		repeat (150) @(posedge mclk);
		channel_grant <= 1'b0;
		keep = 0;
		perr = 0;
	endtask : fin
	// prints the counts and the verdict, then stops
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		logic [31:0] s;
		logic [17:0] h;
		int i;
		repeat (5) @(posedge mclk);
		arst_n <= 1'b1;
		rd(REG_STAT, s);
		`CHK(s, 32'h0)
		`CHK({channel_request, run, control_request_strobe, drv_data_oe, write_strobe, device_word_pulse}, 6'h0)
		rd(4'hf, s);
		`CHK(s, 32'h0)
		// write of three words; a second command while busy must be lost
		go(FN_WRITE, 3);
		rd(REG_STAT, s);
		`CHK({channel_request, s[1:0]}, 3'b101)
		wr(REG_CMD, {4'h0, 3'h2, 1'b1, FN_READ, ~ptr});
		channel_grant <= 1'b1;
		for (i = 0; i < 300 && control_request_strobe !== 1'b1; i++)
			@(posedge mclk);
		`CHK({drv_func, drive_select}, {FN_WRITE, 3'h5})
		fin(15'h0002);
		`CHK(drive.got.size(), exph.size())
		while (drive.got.size() != 0 && exph.size() != 0)
		begin
			h = drive.got.pop_front();
			`CHK(h, exph.pop_front())
		end
		// read of two words from a slow drive
		rdm = 1;
		drive.dly = 600;
		drive.nhalf = 4;
		go(FN_READ, 2);
		channel_grant <= 1'b1;
		for (i = 0; i < 300 && control_request_strobe !== 1'b1; i++)
			@(posedge mclk);
		`CHK(drv_func, FN_READ)
		fin(15'h0002);
		`CHK(expw.size(), 0)
		rdm = 0;
		drive.dly = 100;
		drive.nhalf = 8;
		// control strobe never answered, then run never answered
		drive.ack_on = 0;
		keep = 1;
		go(FN_WRITE, 1);
		channel_grant <= 1'b1;
		fin(15'h000e);
		drive.ack_on = 1;
		drive.runack_on = 0;
		keep = 1;
		go(FN_WRITE, 1);
		channel_grant <= 1'b1;
		fin(15'h0016);
		drive.runack_on = 1;
		// start inhibits: power failure, illegal code, access error
		for (i = 0; i < 3; i++)
		begin
			drive.drv.power_failure = (i == 0);
			drive.drv.selected_drive_access_error = (i == 2);
			repeat (4) @(posedge mclk);
			go((i == 1) ? 6'h05 : FN_WRITE, 0);
			`CHK(channel_request, 1'b0)
			fin(15'h0002 | (15'h0800 >> i));
		end
		drive.drv.selected_drive_access_error = 1'b0;
		// let the cleared pin pass the synchroniser before the next command
		repeat (4) @(posedge mclk);
		// class A fault while still waiting for the channel
		go(FN_WRITE, 1);
		drive.drv.drive_fault_line = 1'b1;
		fin(15'h0102);
		drive.drv.drive_fault_line = 1'b0;
		// class B fault in mid-block with error stop disabled
		wr(REG_CTRL, 32'h1);
		go(FN_WRITE, 2);
		channel_grant <= 1'b1;
		for (i = 0; i < 300 && drv_data_oe !== 1'b1; i++)
			@(posedge mclk);
		`CHK(drv_data_oe, 1'b1)
		drive.drv.fault_class_b = 1'b1;
		drive.drv.drive_fault_line = 1'b1;
		fin(15'h010a);
		drive.drv.drive_fault_line = 1'b0;
		drive.drv.fault_class_b = 1'b0;
		// parity error on a channel word with error stop disabled
		perr = 1;
		go(FN_WRITE, 2);
		channel_grant <= 1'b1;
		fin(15'h0022);
		wr(REG_CTRL, 32'h0);
		// read with a drive parity error: the first half stops the transfer
		rdm = 1;
		drive.drv.drive_parity_error = 1'b1;
		go(FN_READ, 2);
		channel_grant <= 1'b1;
		fin(15'h0042);
		drive.drv.drive_parity_error = 1'b0;
		// read with nobody taking words: a strobe on a full assembly overruns
		keep = 1;
		go(FN_READ, 0);
		channel_grant <= 1'b1;
		fin(15'h0082);
		rdm = 0;
		// one word while the channel stays granted: third strobe overruns
		keep = 1;
		go(FN_WRITE, 1);
		channel_grant <= 1'b1;
		fin(15'h0082);
		`CHK(channel_request, 1'b0)
		final_report;
	end
	// hang guard, far beyond the expected run time
	initial
	begin
		#1000000;
		bad_count++;
		final_report;
	end
endmodule : test_drive_channel_transfer_sequencer
